// ==== pkg/fmt_pkg.sv ====
// constants and types for the quad-channel serial output formatter
// assumes 14-bit offset-binary samples arrive from the converter core on clk_i
package fmt_pkg;
  localparam int SAMPLE_W = 14;
  localparam int NUM_CH = 4;
  localparam int NUM_LANE = 8;
  localparam int FIELD_W = 16;
  localparam int CONV_LATENCY = 12;
  localparam int MAX_EXTRA = 2;
  localparam int HS_WAIT = 40;
  // full-scale clamp codes, held in offset binary
  localparam logic [13:0] OFFS_POS_FULL = 14'h3FFF;
  localparam logic [13:0] OFFS_NEG_FULL = 14'h0000;
  localparam logic [13:0] SIGN_FLIP = 14'h2000;
  localparam logic [13:0] TOGGLE_A = 14'h2AAA;
  localparam logic [13:0] TOGGLE_B = 14'h1555;
  localparam logic [13:0] ALL_ONES = 14'h3FFF;
  localparam logic [15:0] DESKEW_FIELD = 16'hAAAA;
  localparam logic [15:0] FIELD_FULL = 16'hFFFF;
  localparam logic [4:0] LAST_BIT = 5'h0F;
  // bit slots per lane per sample
  localparam logic [4:0] BITS_WORD14 = 5'h0E;
  localparam logic [4:0] BITS_WORD16 = 5'h10;
  localparam logic [4:0] BITS_HALF14 = 5'h07;
  localparam logic [4:0] BITS_HALF16 = 5'h08;
  // driver current select codes and their value in tenths of a milliamp
  localparam logic [1:0] CURSEL_3P5 = 2'h0;
  localparam logic [1:0] CURSEL_2P5 = 2'h1;
  localparam logic [1:0] CURSEL_3P0 = 2'h2;
  localparam logic [6:0] CUR_3P5 = 7'h23;
  localparam logic [6:0] CUR_2P5 = 7'h19;
  localparam logic [6:0] CUR_3P0 = 7'h1E;
  localparam logic [6:0] CUR_4P5 = 7'h2D;
  localparam logic [4:0] TERM_RESET = 5'h00;
  typedef enum logic [2:0] {
    PAT_OFF = 3'h0, PAT_ZEROS = 3'h1, PAT_ONES = 3'h2, PAT_TOGGLE = 3'h3,
    PAT_CUSTOM = 3'h4, PAT_SYNC = 3'h5, PAT_DESKEW = 3'h6
  } pattern_t;
  typedef enum logic [1:0] {ORD_BYTE = 2'h0, ORD_BIT = 2'h1, ORD_WORD = 2'h2} order_t;
endpackage

// ==== rtl/serial_out_formatter.sv ====
// quad-channel output coding, test patterns, lane mapping and serializer
// assumes samples and configuration come from logic on clk_i; link_clk_i is the bit-slot clock
`timescale 1ns/100ps
module serial_out_formatter #(
  parameter int CONV_LAT = fmt_pkg::CONV_LATENCY
) (
  // clocks and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  // converter samples, offset binary, with overrange flags
  input wire logic [fmt_pkg::NUM_CH-1:0][fmt_pkg::SAMPLE_W-1:0] sample_i,
  input wire logic [fmt_pkg::NUM_CH-1:0] over_pos_i,
  input wire logic [fmt_pkg::NUM_CH-1:0] over_neg_i,
  // interface configuration
  input wire logic two_wire_i,
  input wire logic ser16_i,
  input wire logic ddr_i,
  input wire fmt_pkg::order_t order_i,
  input wire logic lsb_first_i,
  input wire logic output_coding_select_i,
  input wire logic clk_delay_ge_period_i,
  input wire fmt_pkg::pattern_t pattern_i,
  input wire logic [7:0] custom_low_i,
  input wire logic [5:0] custom_high_i,
  // driver settings
  input wire logic [1:0] driver_current_select_i,
  input wire logic driver_current_x2_i,
  input wire logic [4:0] term_clk_i,
  input wire logic [4:0] term_data_i,
  output logic [6:0] driver_current_tenth_ma_o,
  output logic [4:0] term_clk_en_o,
  output logic [4:0] term_data_en_o,
  // serial link, on link_clk_i
  output logic chan1_lane_low_o,
  output logic chan1_lane_high_o,
  output logic chan2_lane_low_o,
  output logic chan2_lane_high_o,
  output logic chan3_lane_low_o,
  output logic chan3_lane_high_o,
  output logic chan4_lane_low_o,
  output logic chan4_lane_high_o,
  output logic forwarded_bit_clock_o,
  output logic frame_clock_o
);
  import fmt_pkg::*;

  localparam int DEPTH = CONV_LAT + MAX_EXTRA;
  // bit positions of the overrange flags inside one delay-line entry
  localparam int POS_AT = NUM_CH * SAMPLE_W;
  localparam int NEG_AT = POS_AT + NUM_CH;
  localparam int ACK_WAIT = HS_WAIT;

  // the tap index and the age counter are five bits wide
  if (CONV_LAT < 1 || DEPTH > 31) begin : g_chk
    $error("CONV_LAT must lie between 1 and 29");
  end

  typedef struct packed {
    logic [DEPTH-1:0][63:0] dly;
    logic tog;
    logic half;
    logic [NUM_LANE-1:0][FIELD_W-1:0] first;
    logic [NUM_LANE-1:0][FIELD_W-1:0] hold;
    logic [4:0] hold_len;
    logic hold_ddr;
    logic req;
    logic ack_meta;
    logic ack_sync;
    logic [6:0] cur;
    logic [4:0] tclk;
    logic [4:0] tdat;
    logic [4:0] age;
  } src_t;

  typedef struct packed {
    logic req_meta;
    logic req_sync;
    logic ack;
    logic [NUM_LANE-1:0][FIELD_W-1:0] frm;
    logic [4:0] len;
    logic ddr;
    logic [4:0] slot;
    logic phase;
    logic bitclk;
    logic frame;
    logic [NUM_LANE-1:0] lanes;
  } link_t;

  src_t s_q, s_d;
  link_t l_q, l_d;
  logic lrst_meta, lrst;

  // per-channel views, kept visible for the checks below
  logic [NUM_CH-1:0][SAMPLE_W-1:0] word;
  logic [NUM_LANE-1:0][FIELD_W-1:0] fld;
  logic [63:0] tap;
  logic [4:0] n_bits;
  logic [4:0] extra;
  logic need_pair;
  logic ready;

  // one lane's bits for one sample, left aligned, first bit out at the top
  function automatic logic [FIELD_W-1:0] lane_field(input logic [FIELD_W-1:0] x, input logic [4:0] n,
      input logic hi, input logic bitw, input logic lsb);
    logic [FIELD_W-1:0] f;
    logic [4:0] j;
    logic [4:0] idx;
    f = '0;
    for (int i = 0; i < FIELD_W; i++) begin
      j = lsb ? 5'(n - 5'(i) - 5'h01) : 5'(i); // reversal stays inside the lane
      if (bitw) begin
        idx = 5'(((n - j - 5'h01) << 1) + {4'h0, hi}); // even or odd bits
      end else begin
        idx = 5'(n - j - 5'h01 + (hi ? n : 5'h00)); // low or high half
      end
      if (5'(i) < n) begin
        f[FIELD_W-1-i] = x[idx[3:0]];
      end
    end
    return f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // sample domain: latency, coding, patterns, lane mapping

  always_comb begin
    logic [SAMPLE_W-1:0] raw;
    logic [SAMPLE_W-1:0] v;
    logic [FIELD_W-1:0] x;
    logic [4:0] len;
    logic [FIELD_W-1:0] lo;
    logic [FIELD_W-1:0] hi;
    raw = '0;
    v = '0;
    x = '0;
    len = '0;
    lo = '0;
    hi = '0;
    s_d = s_q;
    ready = 1'b0;
    // serializer latency only in two-wire DDR modes
    if (two_wire_i && ddr_i) begin
      extra = ser16_i ? {4'h0, clk_delay_ge_period_i} : (clk_delay_ge_period_i ? 5'h02 : 5'h01);
    end else begin
      extra = 5'h00;
    end
    s_d.dly = {s_q.dly[DEPTH-2:0], {over_neg_i, over_pos_i, sample_i}};
    tap = s_q.dly[5'(CONV_LAT - 1) + extra];
    s_d.tog = ~s_q.tog;
    // counts up to the line depth, so checks skip taps still holding reset zeros
    s_d.age = (s_q.age == 5'(DEPTH)) ? s_q.age : 5'(s_q.age + 5'h01);
    // lane width per sample
    if (!two_wire_i || order_i == ORD_WORD) begin
      n_bits = ser16_i ? BITS_WORD16 : BITS_WORD14;
    end else begin
      n_bits = ser16_i ? BITS_HALF16 : BITS_HALF14;
    end
    need_pair = two_wire_i && (order_i == ORD_WORD || (ddr_i && !ser16_i));
    len = (need_pair && order_i != ORD_WORD) ? 5'(n_bits << 1) : n_bits;
    for (int c = 0; c < NUM_CH; c++) begin
      raw = tap[c*SAMPLE_W +: SAMPLE_W];
      if (tap[POS_AT+c]) begin
        raw = OFFS_POS_FULL;
      end else if (tap[NEG_AT+c]) begin
        raw = OFFS_NEG_FULL;
      end
      v = output_coding_select_i ? raw : raw ^ SIGN_FLIP;
      // every channel takes the same pattern
      unique case (pattern_i)
        PAT_ZEROS: v = '0;
        PAT_ONES: v = ALL_ONES;
        PAT_TOGGLE: v = s_q.tog ? TOGGLE_A : TOGGLE_B;
        PAT_CUSTOM: v = {custom_high_i, custom_low_i};
        default: v = v;
      endcase
      word[c] = v;
      x = {2'h0, v}; // zero pad on the msb side for 16x
      // mapping applied after coding and pattern choice
      lo = lane_field(x, n_bits, 1'b0, order_i == ORD_BIT, lsb_first_i);
      hi = two_wire_i && order_i != ORD_WORD ? lane_field(x, n_bits, 1'b1, order_i == ORD_BIT, lsb_first_i) : '0;
      if (pattern_i == PAT_SYNC) begin
        lo = ~(FIELD_FULL >> ((n_bits + 5'h01) >> 1));
        hi = two_wire_i ? lo : '0;
      end else if (pattern_i == PAT_DESKEW) begin
        // only this sample's slots, so the second half of a paired frame restarts at one
        lo = DESKEW_FIELD & ~(FIELD_FULL >> n_bits);
        hi = two_wire_i ? lo : '0;
      end
      fld[2*c] = lo;
      fld[2*c+1] = hi;
    end
    // pairing for half-rate frames
    if (need_pair && !s_q.half) begin
      s_d.first = fld;
      s_d.half = 1'b1;
    end else begin
      s_d.half = 1'b0;
      ready = 1'b1;
    end
    // hand a frame word over only when the link has taken the last one
    if (ready && s_q.req == s_q.ack_sync) begin
      for (int k = 0; k < NUM_LANE; k++) begin
        if (!need_pair) begin
          s_d.hold[k] = fld[k];
        end else if (order_i == ORD_WORD) begin
          s_d.hold[k] = k[0] ? fld[k-1] : s_q.first[k]; // sample N low, N+1 high
        end else begin
          s_d.hold[k] = s_q.first[k] | (fld[k] >> n_bits);
        end
      end
      s_d.hold_len = len;
      s_d.hold_ddr = ddr_i;
      s_d.req = ~s_q.req;
    end
    s_d.ack_meta = l_q.ack;
    s_d.ack_sync = s_q.ack_meta;
    // driver settings
    unique case (driver_current_select_i)
      CURSEL_3P5: s_d.cur = CUR_3P5;
      CURSEL_2P5: s_d.cur = CUR_2P5;
      CURSEL_3P0: s_d.cur = CUR_3P0;
      default: s_d.cur = CUR_4P5;
    endcase
    if (driver_current_x2_i) begin
      s_d.cur = 7'(s_d.cur << 1);
    end
    s_d.tclk = term_clk_i;
    s_d.tdat = term_data_i;
  end

  // sample domain registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.hold_len <= BITS_HALF14;
      s_q.cur <= CUR_3P5;
      s_q.tclk <= TERM_RESET;
      s_q.tdat <= TERM_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign driver_current_tenth_ma_o = s_q.cur;
  assign term_clk_en_o = s_q.tclk;
  assign term_data_en_o = s_q.tdat;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: bit slots, frame clock, lane outputs

  // reset release synchronised to the link clock
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lrst_meta <= 1'b1;
      lrst <= 1'b1;
    end else begin
      lrst_meta <= 1'b0;
      lrst <= lrst_meta;
    end
  end

  always_comb begin
    logic step;
    step = 1'b0;
    l_d = l_q;
    l_d.req_meta = s_q.req;
    l_d.req_sync = l_q.req_meta;
    l_d.phase = ~l_q.phase;
    l_d.bitclk = ~l_q.bitclk; // bit clock never stops
    // SDR moves one bit per bit-clock period, DDR one per edge
    step = l_q.ddr || l_q.phase;
    if (step) begin
      for (int k = 0; k < NUM_LANE; k++) begin
        l_d.lanes[k] = l_q.frm[k][4'(LAST_BIT - l_q.slot)];
      end
      l_d.frame = l_q.slot < 5'((l_q.len + 5'h01) >> 1); // rises with the first bit
      if (l_q.slot >= 5'(l_q.len - 5'h01)) begin
        l_d.slot = '0;
        // a stalled source repeats the last frame word
        if (l_q.req_sync != l_q.ack) begin
          l_d.frm = s_q.hold;
          l_d.len = s_q.hold_len;
          l_d.ddr = s_q.hold_ddr;
          l_d.ack = l_q.req_sync;
        end
      end else begin
        l_d.slot = 5'(l_q.slot + 5'h01);
      end
    end
  end

  // link domain registers
  always_ff @(posedge link_clk_i or posedge lrst) begin
    if (lrst) begin
      l_q <= '0;
      l_q.len <= BITS_HALF14;
    end else begin
      l_q <= l_d;
    end
  end

  assign chan1_lane_low_o = l_q.lanes[0];
  assign chan1_lane_high_o = l_q.lanes[1];
  assign chan2_lane_low_o = l_q.lanes[2];
  assign chan2_lane_high_o = l_q.lanes[3];
  assign chan3_lane_low_o = l_q.lanes[4];
  assign chan3_lane_high_o = l_q.lanes[5];
  assign chan4_lane_low_o = l_q.lanes[6];
  assign chan4_lane_high_o = l_q.lanes[7];
  assign forwarded_bit_clock_o = l_q.bitclk;
  assign frame_clock_o = l_q.frame;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence req_sent;
    $changed(s_q.req);
  endsequence

  sequence ack_back;
    ##[1:ACK_WAIT] (s_q.ack_sync == s_q.req);
  endsequence

  pos_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pattern_i == PAT_OFF && tap[POS_AT]) |-> word[0] == (output_coding_select_i ? 14'h3FFF : 14'h1FFF))
    else $error("positive clamp code wrong");
  neg_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pattern_i == PAT_OFF && !tap[POS_AT] && tap[NEG_AT]) |-> word[0] == (output_coding_select_i ? 14'h0000 : 14'h2000))
    else $error("negative clamp code wrong");
  toggle_alt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pattern_i == PAT_TOGGLE && $past(pattern_i) == PAT_TOGGLE) |-> word[0] == ~$past(word[0]))
    else $error("toggle pattern did not alternate");
  byte_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (two_wire_i && !ser16_i && order_i == ORD_BYTE && !lsb_first_i && pattern_i < PAT_SYNC)
    |-> fld[0][15:9] == word[0][6:0] && fld[1][15:9] == word[0][13:7])
    else $error("byte-wise mapping wrong");
  bit_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (two_wire_i && !ser16_i && order_i == ORD_BIT && lsb_first_i && pattern_i < PAT_SYNC)
    |-> fld[0][15] == word[0][0] && fld[1][9] == word[0][13])
    else $error("bit-wise lsb-first mapping wrong");
  sync_word_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!two_wire_i && !ser16_i && pattern_i == PAT_SYNC) |-> fld[0][15:2] == 14'h3F80)
    else $error("one-wire sync pattern wrong");
  latency_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.age == 5'(DEPTH) && (!two_wire_i || !ddr_i)) |-> tap == $past(s_d.dly[0], CONV_LAT))
    else $error("latency tap wrong");
  ddr_latency_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_q.age == 5'(DEPTH) && two_wire_i && ddr_i && !ser16_i && clk_delay_ge_period_i)
    |-> tap == $past(s_d.dly[0], CONV_LAT + MAX_EXTRA))
    else $error("two-wire ddr latency wrong");
  handshake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    req_sent |-> ack_back)
    else $error("link did not take frame word");
  frame_start_a: assert property (@(posedge link_clk_i) disable iff (lrst)
    $rose(l_q.frame) |-> $past(l_q.slot) == 5'h00)
    else $error("frame clock rose away from word start");
endmodule

// ==== sim/lane_receiver.sv ====
// far-side deserializer model for the eight formatter lanes
// assumes lanes and frame clock change on link_clk_i rising edges, one bit each edge
`timescale 1ns/100ps
module lane_receiver (
  // link side
  input wire logic link_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] lanes_i,
  input wire logic frame_i,
  input wire logic bit_clk_i,
  // captured words
  output logic [7:0][15:0] word_o,
  output logic [4:0] nbits_o,
  output int frames_o,
  output int bclk_err_o
);
  logic [7:0][15:0] acc_q;
  logic [4:0] cnt_q;
  logic frame_q;
  logic bclk_q;
  ////////////////////////////////////////
  // sample mid-bit on the falling edge, away from the launch edge
  always_ff @(negedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q <= '0;
      cnt_q <= '0;
      frame_q <= 1'b0;
      bclk_q <= 1'b0;
      word_o <= '0;
      nbits_o <= '0;
      frames_o <= 0;
      bclk_err_o <= 0;
    end else begin
      frame_q <= frame_i;
      bclk_q <= bit_clk_i;
      // a stalled bit clock would lose bits at a real receiver
      if (frames_o > 0 && bit_clk_i === bclk_q) begin
        bclk_err_o <= bclk_err_o + 1;
      end
      // word boundary slips to the frame clock rise
      if (frame_i && !frame_q) begin
        word_o <= acc_q;
        nbits_o <= cnt_q;
        frames_o <= frames_o + 1;
        cnt_q <= 5'h01;
      end else begin
        cnt_q <= cnt_q + 5'h01;
      end
      for (int i = 0; i < 8; i++) begin
        acc_q[i] <= {acc_q[i][14:0], lanes_i[i]};
      end
    end
  end
endmodule

// ==== sim/serial_out_formatter_test.sv ====
// self-checking bench for the quad-channel serial output formatter
// assumes fmt_pkg is compiled first and lane_receiver stands at the far side
`timescale 1ns/100ps
module serial_out_formatter_test;
  import fmt_pkg::*;
  // stimulus
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic link_clk_i = 1'b0;
  logic [NUM_CH-1:0][SAMPLE_W-1:0] smp = '0;
  logic [NUM_CH-1:0] opos = '0;
  logic [NUM_CH-1:0] oneg = '0;
  logic tw = 1'b0, s16 = 1'b0, lsb = 1'b0, cod = 1'b0, dly = 1'b0, x2 = 1'b0;
  logic ddr = 1'b1;
  order_t ord = ORD_BYTE;
  pattern_t pat = PAT_OFF;
  logic [13:0] cust = 14'h2CA5;
  logic [1:0] csel = '0;
  logic [4:0] tc = '0, td = '0;
  // observed
  logic [6:0] cur;
  logic [4:0] tco, tdo;
  logic [7:0] ln;
  logic bclk, frm;
  logic [7:0][15:0] word;
  logic [4:0] nbits;
  int frames, bclk_err;
  int n_mismatch = 0;
  int compares = 0;
  ////////////////////////////////////////
  // the receiver samples every link cycle, so an sdr bit is taken twice
  serial_out_formatter dut (
    .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .sample_i(smp), .over_pos_i(opos),
    .over_neg_i(oneg), .two_wire_i(tw), .ser16_i(s16), .ddr_i(ddr), .order_i(ord), .lsb_first_i(lsb),
    .output_coding_select_i(cod), .clk_delay_ge_period_i(dly), .pattern_i(pat), .custom_low_i(cust[7:0]),
    .custom_high_i(cust[13:8]), .driver_current_select_i(csel), .driver_current_x2_i(x2),
    .term_clk_i(tc), .term_data_i(td), .driver_current_tenth_ma_o(cur), .term_clk_en_o(tco),
    .term_data_en_o(tdo), .chan1_lane_low_o(ln[0]), .chan1_lane_high_o(ln[1]), .chan2_lane_low_o(ln[2]),
    .chan2_lane_high_o(ln[3]), .chan3_lane_low_o(ln[4]), .chan3_lane_high_o(ln[5]),
    .chan4_lane_low_o(ln[6]), .chan4_lane_high_o(ln[7]), .forwarded_bit_clock_o(bclk), .frame_clock_o(frm)
  );
  lane_receiver far (
    .link_clk_i(link_clk_i), .rst_i(rst_i), .lanes_i(ln), .frame_i(frm), .bit_clk_i(bclk),
    .word_o(word), .nbits_o(nbits), .frames_o(frames), .bclk_err_o(bclk_err)
  );
  // sample clock and an unrelated link clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    #3.3;
    forever #7.5 link_clk_i = ~link_clk_i;
  end
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic [15:0] rev(input logic [15:0] v, input int n);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < n; i++) r[i] = v[n-1-i];
    return r;
  endfunction
  function automatic logic [15:0] dup7(input logic [6:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 7; i++) r[2*i+:2] = {2{v[i]}};
    return r;
  endfunction
  function automatic logic [6:0] pick(input logic [13:0] v, input int odd);
    for (int i = 0; i < 7; i++) pick[i] = v[2*i+odd];
  endfunction
  task automatic cfg(input logic w, input logic s, input order_t o, input logic l, input logic c,
                     input pattern_t p);
    @(posedge clk_i);
    tw <= w;
    s16 <= s;
    ord <= o;
    lsb <= l;
    cod <= c;
    pat <= p;
  endtask
  // let the pipeline drain, then wait for four fresh frames
  task automatic settle();
    int f;
    repeat (CONV_LATENCY + 4) @(posedge clk_i);
    f = frames;
    for (int i = 0; i < 400; i++) begin
      @(posedge clk_i);
      if (frames >= f + 4) return;
    end
    n_mismatch++;
    $display("unexpected frame wait: expected 4 frames seen %0d", frames - f);
    final_report();
  endtask
  task automatic lanes(input string what, input logic [15:0] e0, input logic [15:0] e1, input int n,
                       input bit both);
    logic [15:0] m;
    m = (16'h0001 << n) - 16'h0001;
    settle();
    chk({what, " bits"}, 16'(n), 16'(nbits));
    for (int c = 0; c < NUM_CH; c++) begin
      chk({what, " low"}, e0, word[2*c] & m);
      if (both) chk({what, " high"}, e1, word[2*c+1] & m);
    end
  endtask
  ////////////////////////////////////////
  task automatic t_driver();
    logic [6:0] base [4] = '{7'h23, 7'h19, 7'h1E, 7'h2D};
    chk("current reset", 16'h0023, 16'(cur));
    chk("term reset", 16'h0000, {6'h00, tco, tdo});
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      csel <= 2'(k >> 1);
      x2 <= k[0];
      tc <= 5'h15 ^ 5'(k);
      td <= 5'h0A ^ 5'(k);
      repeat (3) @(posedge clk_i);
      chk("current", 16'(base[k>>1]) << k[0], 16'(cur));
      chk("term", {6'h00, 5'h15 ^ 5'(k), 5'h0A ^ 5'(k)}, {6'h00, tco, tdo});
    end
  endtask
  task automatic t_one_wire();
    logic [13:0] e;
    for (int k = 0; k < 4; k++) begin
      cfg(1'b0, 1'b0, ORD_BYTE, k[1], k[0], PAT_OFF);
      smp <= {4{14'h1234}};
      e = k[0] ? 14'h1234 : 14'h3234;
      lanes("one wire", k[1] ? rev(16'(e), 14) : 16'(e), 16'h0, 14, 0);
    end
  endtask
  task automatic t_over();
    logic [15:0] e [4] = '{16'h1FFF, 16'h3FFF, 16'h2000, 16'h0000};
    for (int k = 0; k < 4; k++) begin
      cfg(1'b0, 1'b0, ORD_BYTE, 1'b0, k[0], PAT_OFF);
      opos <= k[1] ? 4'h0 : 4'hF;
      oneg <= k[1] ? 4'hF : 4'h0;
      lanes("overrange", e[k], 16'h0, 14, 0);
    end
    @(posedge clk_i);
    opos <= 4'h0;
    oneg <= 4'h0;
  endtask
  task automatic t_two_wire();
    logic [13:0] s;
    logic [6:0] lo, hi;
    s = 14'h2C5B;
    for (int k = 0; k < 8; k++) begin
      cfg(1'b1, 1'b0, k[0] ? ORD_BIT : ORD_BYTE, k[1], 1'b1, PAT_OFF);
      smp <= {4{s}};
      dly <= k[2];
      lo = k[0] ? pick(s, 0) : s[6:0];
      hi = k[0] ? pick(s, 1) : s[13:7];
      lo = k[1] ? 7'(rev(16'(lo), 7)) : lo;
      hi = k[1] ? 7'(rev(16'(hi), 7)) : hi;
      lanes("two wire", 16'({lo, lo}), 16'({hi, hi}), 14, 1);
    end
    cfg(1'b1, 1'b1, ORD_BYTE, 1'b0, 1'b1, PAT_OFF);
    lanes("16x", 16'h005B, 16'h002C, 8, 1);
    // sdr: seven bits per lane, each standing two link cycles
    cfg(1'b1, 1'b0, ORD_BYTE, 1'b0, 1'b1, PAT_OFF);
    ddr <= 1'b0;
    lanes("sdr", dup7(s[6:0]), dup7(s[13:7]), 14, 1);
    ddr <= 1'b1;
  endtask
  task automatic t_patterns();
    pattern_t p [8] = '{PAT_ZEROS, PAT_ONES, PAT_CUSTOM, PAT_SYNC, PAT_DESKEW, PAT_SYNC, PAT_DESKEW, PAT_CUSTOM};
    logic [15:0] e0 [8] = '{16'h0, 16'h3FFF, 16'h2CA5, 16'h3F80, 16'h2AAA, 16'h3C78, 16'h2AD5, 16'h12A5};
    logic [15:0] e1 [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h3C78, 16'h2AD5, 16'h2CD9};
    for (int i = 0; i < 8; i++) begin
      cfg(i > 4, 1'b0, ORD_BYTE, 1'b0, 1'b0, p[i]);
      lanes("pattern", e0[i], e1[i], 14, i > 4);
    end
  endtask
  task automatic t_toggle();
    logic [13:0] w;
    logic [13:0] u;
    cfg(1'b1, 1'b0, ORD_WORD, 1'b0, 1'b1, PAT_TOGGLE);
    settle();
    chk("word wise bits", 16'h000E, 16'(nbits));
    for (int c = 0; c < NUM_CH; c++) begin
      w = word[2*c][13:0];
      u = word[2*c+1][13:0];
      chk("toggle pair", 16'h3FFF, 16'(w ^ u));
      chk("toggle low", 16'h0001, 16'((w === 14'h2AAA) || (w === 14'h1555)));
      chk("toggle high", 16'h0001, 16'((u === 14'h2AAA) || (u === 14'h1555)));
    end
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_driver();
    t_one_wire();
    t_over();
    t_two_wire();
    t_patterns();
    t_toggle();
    chk("bit clock stalls", 16'h0, 16'(bclk_err));
    final_report();
  end
endmodule
